// ==== pkg/supervisor_params.svh ====
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH

// core clock rate expressed as cycles per millisecond (200 MHz)
`define SV_CLK_MHZ        200
`define SV_CYC_PER_MS     (`SV_CLK_MHZ * 1000)

// counter width, enough for the longest timeout (240e6 cycles)
`define SV_CNT_W          28

// reset hold after the last cause clears, in ms
`define SV_HOLD_MS        250
// debounce qualify time for the button, in ms
`define SV_DEBOUNCE_MS    10
// watchdog timeouts per select setting, in ms
`define SV_TO_GND_MS      150
`define SV_TO_FLOAT_MS    600
`define SV_TO_VCC_MS      1200

// cycle counts derived from the times above
`define SV_HOLD_CYC       (`SV_HOLD_MS * `SV_CYC_PER_MS)
`define SV_DEBOUNCE_CYC   (`SV_DEBOUNCE_MS * `SV_CYC_PER_MS)
`define SV_TO_GND_CYC     (`SV_TO_GND_MS * `SV_CYC_PER_MS)
`define SV_TO_FLOAT_CYC   (`SV_TO_FLOAT_MS * `SV_CYC_PER_MS)
`define SV_TO_VCC_CYC     (`SV_TO_VCC_MS * `SV_CYC_PER_MS)

// synchroniser depth and vector layout of the pin inputs
`define SV_SYNC_DEPTH     3
`define SV_PIN_W          6
`define SV_PIN_TRIP       0
`define SV_PIN_SEL_LO     1
`define SV_PIN_SEL_HI     2
`define SV_PIN_KICK       3
`define SV_PIN_BUTTON     4
`define SV_PIN_SUPPLY     5
// idle levels: supply, button and strobe high, selects low
`define SV_PIN_IDLE       6'h38

`endif

// ==== pkg/supervisor_pkg.sv ====
package supervisor_pkg;

  // three-state timeout select as seen after the pin buffer
  typedef enum logic [1:0] {
    TD_GND,
    TD_FLOAT,
    TD_VCC
  } period_sel_t;

  typedef enum logic {
    ST_HOLD,
    ST_RUN
  } sup_state_t;

  // complementary system reset pair
  typedef struct packed {
    logic active;
    logic active_n;
  } reset_pair_t;

endpackage : supervisor_pkg

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
`include "supervisor_params.svh"

module pin_sync #(
  parameter int unsigned      WIDTH = `SV_PIN_W,
  parameter logic [WIDTH-1:0] IDLE  = '0
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  // synchronised levels
  output logic      [WIDTH-1:0] level_q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [`SV_SYNC_DEPTH-1:0] sh_q;
      // idle level is a parameter, so the async reset loads a constant
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          sh_q <= {`SV_SYNC_DEPTH{IDLE[i]}};
        end else begin
          sh_q <= {sh_q[`SV_SYNC_DEPTH-2:0], pin_in[i]};
        end
      end
      // a change counts only once the second and third stage agree
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          level_q[i] <= IDLE[i];
        end else if (sh_q[1] == sh_q[2]) begin
          level_q[i] <= sh_q[2];
        end
      end
    end
  endgenerate

endmodule : pin_sync

// ==== rtl/button_filter.sv ====
`timescale 1ns/1ps
`include "supervisor_params.svh"

module button_filter #(
  parameter int unsigned DEBOUNCE_CYC = `SV_DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // synchronised active-low button level
  input  wire logic button_n,
  // debounced press indication
  output logic      pressed_q
);

  logic [`SV_CNT_W-1:0] stable_cnt_q;
  logic                 differs;

  assign differs = (~button_n) != pressed_q;

  // any bounce back to the accepted level restarts the qualify time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stable_cnt_q <= '0;
    end else if (!differs) begin
      stable_cnt_q <= '0;
    end else if (stable_cnt_q != `SV_CNT_W'(DEBOUNCE_CYC - 1)) begin
      stable_cnt_q <= stable_cnt_q + `SV_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pressed_q <= 1'b0;
    end else if (differs && stable_cnt_q == `SV_CNT_W'(DEBOUNCE_CYC - 1)) begin
      pressed_q <= ~button_n;
    end
  end

  AST_DEBOUNCE_STABLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(pressed_q) |-> $past(pressed_q) != $past(~button_n))
    else $error("debounced button changed without a stable differing input");

endmodule : button_filter

// ==== rtl/supervisor_watchdog_reset.sv ====
// Overview of operation
// - debounce button; press gives at least 250 ms reset
// - button input is active low
// - button hold time starts at release
// - power-up reset held at least 250 ms
// - supply low asserts both reset outputs
// - select picks 150, 600 or 1200 ms timeout
// - watchdog counts only while reset inactive
// - kick falling edge restarts timeout; levels don't
// - expiry asserts reset 250 ms, then restarts
// - watchdog cannot be disabled
`timescale 1ns/1ps
`include "supervisor_params.svh"

module supervisor_watchdog_reset #(
  parameter int unsigned HOLD_CYC     = `SV_HOLD_CYC,
  parameter int unsigned DEBOUNCE_CYC = `SV_DEBOUNCE_CYC,
  parameter int unsigned TO_GND_CYC   = `SV_TO_GND_CYC,
  parameter int unsigned TO_FLOAT_CYC = `SV_TO_FLOAT_CYC,
  parameter int unsigned TO_VCC_CYC   = `SV_TO_VCC_CYC
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // supply monitor
  input  wire logic                      supply_low,
  input  wire logic                      supply_trip_sel,
  output logic                           trip_level_sel_q,
  // processor side
  input  wire logic                      manual_button_reset_n,
  input  wire logic                      watchdog_kick_n,
  input  wire logic [1:0]                timeout_period_sel,
  // system reset pair
  output supervisor_pkg::reset_pair_t    sys_reset
);

  logic [`SV_PIN_W-1:0]        pins;
  localparam logic [`SV_PIN_W-1:0] PINS_IDLE = `SV_PIN_IDLE;
  logic [`SV_PIN_W-1:0]        pins_s;
  logic                        supply_low_s;
  logic                        kick_n_s;
  logic                        button_pressed;
  supervisor_pkg::period_sel_t period_sel_s;

  supervisor_pkg::sup_state_t  state_q;
  supervisor_pkg::sup_state_t  state_d;
  logic [`SV_CNT_W-1:0]        hold_cnt_q;
  logic [`SV_CNT_W-1:0]        wdt_cnt_q;
  logic [`SV_CNT_W-1:0]        wdt_limit;
  logic                        kick_prev_q;
  logic                        kick_fall;
  logic                        cause;
  logic                        hold_done;
  logic                        expire;
  logic                        rst_active_q;
  logic                        rst_active_n_q;

  // pin inputs, idle levels chosen so power-up sees no spurious event
  assign pins[`SV_PIN_TRIP]                    = supply_trip_sel;
  assign pins[`SV_PIN_SEL_HI:`SV_PIN_SEL_LO]   = timeout_period_sel;
  assign pins[`SV_PIN_KICK]                    = watchdog_kick_n;
  assign pins[`SV_PIN_BUTTON]                  = manual_button_reset_n;
  assign pins[`SV_PIN_SUPPLY]                  = supply_low;

  pin_sync #(
    .WIDTH    (`SV_PIN_W),
    .IDLE     (PINS_IDLE)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   (pins),
    .level_q  (pins_s)
  );

  assign supply_low_s = pins_s[`SV_PIN_SUPPLY];
  assign kick_n_s     = pins_s[`SV_PIN_KICK];
  assign period_sel_s = supervisor_pkg::period_sel_t'(pins_s[`SV_PIN_SEL_HI:`SV_PIN_SEL_LO]);

  button_filter #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_button_filter (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .button_n     (pins_s[`SV_PIN_BUTTON]),
    .pressed_q    (button_pressed)
  );

  // trip level is only forwarded to the analog comparator
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_level_sel_q <= 1'b0;
    end else begin
      trip_level_sel_q <= pins_s[`SV_PIN_TRIP];
    end
  end

  // any live cause keeps reset asserted and the hold count at zero
  assign cause = supply_low_s | button_pressed;

  // timeout per select; an undefined code falls back to the longest
  always_comb begin
    unique case (period_sel_s)
      supervisor_pkg::TD_GND:   wdt_limit = `SV_CNT_W'(TO_GND_CYC - 1);
      supervisor_pkg::TD_FLOAT: wdt_limit = `SV_CNT_W'(TO_FLOAT_CYC - 1);
      supervisor_pkg::TD_VCC:   wdt_limit = `SV_CNT_W'(TO_VCC_CYC - 1);
      default:                  wdt_limit = `SV_CNT_W'(TO_VCC_CYC - 1);
    endcase
  end

  // strobe edge detect works on the settled level only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      kick_prev_q <= 1'b1;
    end else begin
      kick_prev_q <= kick_n_s;
    end
  end

  assign kick_fall = kick_prev_q & ~kick_n_s;
  assign hold_done = hold_cnt_q == `SV_CNT_W'(HOLD_CYC - 1);
  // at-or-above, so a select lowered mid-run cannot let the count overshoot and wrap
  assign expire    = (state_q == supervisor_pkg::ST_RUN) && (wdt_cnt_q >= wdt_limit);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      supervisor_pkg::ST_HOLD: begin
        if (!cause && hold_done) begin
          state_d = supervisor_pkg::ST_RUN;
        end
      end
      supervisor_pkg::ST_RUN: begin
        // no enable term: only a cause or expiry leaves run
        if (cause || expire) begin
          state_d = supervisor_pkg::ST_HOLD;
        end
      end
    endcase
  end

  // async reset is the power-up event: start in hold with count zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= supervisor_pkg::ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // hold counter restarts while any cause is live, so timing begins at release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_q <= '0;
    end else if (state_q != supervisor_pkg::ST_HOLD || cause) begin
      hold_cnt_q <= '0;
    end else if (!hold_done) begin
      hold_cnt_q <= hold_cnt_q + `SV_CNT_W'(1);
    end
  end

  // watchdog idles in reset and restarts on every falling strobe edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt_q <= '0;
    end else if (state_q != supervisor_pkg::ST_RUN || state_d != supervisor_pkg::ST_RUN) begin
      wdt_cnt_q <= '0;
    end else if (kick_fall) begin
      wdt_cnt_q <= '0;
    end else begin
      wdt_cnt_q <= wdt_cnt_q + `SV_CNT_W'(1);
    end
  end

  // both outputs come from twin flops fed by the same term
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_active_q   <= 1'b1;
      rst_active_n_q <= 1'b0;
    end else begin
      rst_active_q   <= state_d == supervisor_pkg::ST_HOLD;
      rst_active_n_q <= state_d != supervisor_pkg::ST_HOLD;
    end
  end

  assign sys_reset.active   = rst_active_q;
  assign sys_reset.active_n = rst_active_n_q;

  // checks

  sequence s_expiry;
    state_q == supervisor_pkg::ST_RUN ##0 wdt_cnt_q >= wdt_limit ##0 !cause;
  endsequence

  sequence s_release;
    state_q == supervisor_pkg::ST_HOLD ##0 !cause ##0 hold_done;
  endsequence

  sequence s_kick_in_run;
    state_q == supervisor_pkg::ST_RUN ##0 kick_fall ##0 !cause ##0 !expire;
  endsequence

  sequence s_enter_run;
    state_q == supervisor_pkg::ST_HOLD ##1 state_q == supervisor_pkg::ST_RUN;
  endsequence

  AST_COMPLEMENT: assert property (@(posedge core_clk) disable iff (!rst_n)
    sys_reset.active != sys_reset.active_n)
    else $error("reset outputs not complementary");

  AST_SUPPLY_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
    supply_low_s |=> sys_reset.active && hold_cnt_q == '0)
    else $error("supply low did not assert reset");

  AST_BUTTON_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
    button_pressed |=> sys_reset.active && !sys_reset.active_n)
    else $error("button press did not assert reset");

  AST_HOLD_FROM_RELEASE: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(button_pressed) && state_q == supervisor_pkg::ST_HOLD |-> hold_cnt_q == '0)
    else $error("hold count did not start at button release");

  AST_MIN_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(sys_reset.active) |-> $past(hold_cnt_q) == `SV_CNT_W'(HOLD_CYC - 1) && !$past(cause))
    else $error("reset released before full hold interval");

  AST_RELEASE_TIMELY: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_release |=> !sys_reset.active && wdt_cnt_q == '0)
    else $error("reset not released after hold with no cause");

  AST_TIMEOUT_SEL: assert property (@(posedge core_clk) disable iff (!rst_n)
    period_sel_s == supervisor_pkg::TD_GND |-> wdt_limit == `SV_CNT_W'(TO_GND_CYC - 1))
    else $error("grounded select gave wrong timeout");

  AST_IDLE_IN_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
    sys_reset.active |-> wdt_cnt_q == '0)
    else $error("watchdog counted during reset");

  AST_KICK_RESTART: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_kick_in_run |=> wdt_cnt_q == '0 && !sys_reset.active)
    else $error("strobe edge did not restart watchdog");

  AST_ALWAYS_COUNTS: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == supervisor_pkg::ST_RUN && !kick_fall && !cause && !expire
      |=> wdt_cnt_q == $past(wdt_cnt_q) + `SV_CNT_W'(1))
    else $error("watchdog stopped counting without strobe");

  AST_EXPIRY_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_expiry |=> sys_reset.active && hold_cnt_q == '0 ##1 sys_reset.active)
    else $error("expiry did not start a reset hold");

  AST_DEBOUNCED_PRESS: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(button_pressed)
      |-> state_q == supervisor_pkg::ST_HOLD || state_d == supervisor_pkg::ST_HOLD)
    else $error("debounced press failed to enter hold");

  // helper: run cycles since the last restart, kept apart from the watchdog counter
  logic [`SV_CNT_W-1:0] quiet_cnt_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_cnt_q <= '0;
    end else if (state_q != supervisor_pkg::ST_RUN || kick_fall) begin
      quiet_cnt_q <= '0;
    end else begin
      quiet_cnt_q <= quiet_cnt_q + `SV_CNT_W'(1);
    end
  end

  AST_FRESH_START: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_enter_run |-> wdt_cnt_q == '0 && !sys_reset.active)
    else $error("watchdog did not start fresh at reset release");

  AST_CAUSE_KEEPS: assert property (@(posedge core_clk) disable iff (!rst_n)
    cause |=> sys_reset.active && hold_cnt_q == '0)
    else $error("live cause did not keep reset asserted");

  AST_CAUSE_STAYS_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == supervisor_pkg::ST_HOLD && cause |=> state_q == supervisor_pkg::ST_HOLD)
    else $error("hold left while a cause was live");

  AST_HOLD_ADVANCES: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == supervisor_pkg::ST_HOLD && !cause && !hold_done
      |=> hold_cnt_q == $past(hold_cnt_q) + `SV_CNT_W'(1))
    else $error("hold count stalled after the last cause cleared");

  AST_HOLD_BOUND: assert property (@(posedge core_clk) disable iff (!rst_n)
    hold_cnt_q <= `SV_CNT_W'(HOLD_CYC - 1))
    else $error("hold count ran past its end");

  AST_OUT_MATCHES_STATE: assert property (@(posedge core_clk) disable iff (!rst_n)
    sys_reset.active == (state_q == supervisor_pkg::ST_HOLD))
    else $error("reset output disagrees with supervisor state");

  AST_TRIP_FORWARD: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> trip_level_sel_q == $past(pins_s[`SV_PIN_TRIP]))
    else $error("trip level select not forwarded");

  AST_NO_EARLY_EXPIRY: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == supervisor_pkg::ST_RUN && quiet_cnt_q < `SV_CNT_W'(TO_GND_CYC - 1)
      |-> !expire)
    else $error("watchdog expired before the shortest timeout");

  AST_EXPIRY_BY_LONGEST: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == supervisor_pkg::ST_RUN && quiet_cnt_q == `SV_CNT_W'(TO_VCC_CYC - 1)
      |-> expire)
    else $error("watchdog ran past the longest timeout");

endmodule : supervisor_watchdog_reset

// ==== test/cpu_partner.sv ====
`timescale 1ns/1ps

module cpu_partner (
  // clock
  input  wire logic                        core_clk,
  // reset pair from the supervisor
  input  wire supervisor_pkg::reset_pair_t sys_reset,
  // bench control
  input  wire logic                        kick_on,
  input  wire logic                        idle_lvl,
  input  wire logic [15:0]                 gap,
  // strobe to the supervisor
  output logic                             watchdog_kick_n
);
  logic [15:0] cnt_q;

  // a processor held in reset cannot strobe, so kicks stop while reset is up
  always_ff @(posedge core_clk) begin
    if (!kick_on || sys_reset.active) begin
      cnt_q           <= 16'h0000;
      watchdog_kick_n <= idle_lvl;
    end else begin
      cnt_q           <= (cnt_q >= gap - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
      // low for 6 cycles so the synchroniser sees both levels
      watchdog_kick_n <= (cnt_q >= 16'h0006);
    end
  end
endmodule : cpu_partner

// ==== test/supervisor_watchdog_reset_tb_top.sv ====
`timescale 1ns/1ps

module supervisor_watchdog_reset_tb_top;
  localparam int HOLD = 20;
  localparam int TG   = 40;
  localparam int TF   = 80;
  localparam int TV   = 160;

  logic                        core_clk;
  logic                        rst_n;
  logic                        supply_low;
  logic                        supply_trip_sel;
  logic                        trip_level_sel_q;
  logic                        manual_button_reset_n;
  logic                        watchdog_kick_n;
  logic [1:0]                  timeout_period_sel;
  supervisor_pkg::reset_pair_t sys_reset;
  logic                        kick_on;
  logic                        idle_lvl;
  logic [15:0]                 gap;
  int                          n_mismatch;
  int                          compares;
  int                          to_tab [4] = '{TG, TF, TV, TV};

  supervisor_watchdog_reset #(
    .HOLD_CYC(HOLD), .DEBOUNCE_CYC(4), .TO_GND_CYC(TG), .TO_FLOAT_CYC(TF), .TO_VCC_CYC(TV)
  ) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .supply_low(supply_low),
    .supply_trip_sel(supply_trip_sel), .trip_level_sel_q(trip_level_sel_q),
    .manual_button_reset_n(manual_button_reset_n), .watchdog_kick_n(watchdog_kick_n),
    .timeout_period_sel(timeout_period_sel), .sys_reset(sys_reset)
  );

  cpu_partner cpu_u (
    .core_clk(core_clk), .sys_reset(sys_reset), .kick_on(kick_on),
    .idle_lvl(idle_lvl), .gap(gap), .watchdog_kick_n(watchdog_kick_n)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk_bit(input logic e, input logic g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_bit

  task automatic chk_rng(input int v, input int lo, input int hi);
    compares++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h..%h got=%h", $time, lo, hi, v);
    end
  endtask : chk_rng

  // counts edges until the reset output reaches v, bounded by lim
  task automatic wait_act(input logic v, input int lim, output int n);
    n = 0;
    while (sys_reset.active !== v && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask : wait_act

  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : step

  always @(negedge core_clk) chk_bit(~sys_reset.active, sys_reset.active_n);

  task automatic t_power_up;
    int n;
    chk_bit(1'b1, sys_reset.active);
    chk_bit(1'b0, trip_level_sel_q);
    @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    wait_act(1'b0, 100, n);
    chk_rng(n, HOLD, HOLD + 8);
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_expiry;
    int n;
    for (int s = 0; s < 4; s++) begin
      wait_act(1'b1, 400, n);
      chk_bit(1'b1, sys_reset.active);
      timeout_period_sel = s[1:0];
      wait_act(1'b0, 100, n);
      chk_rng(n, HOLD - 1, HOLD + 2);
      wait_act(1'b1, 400, n);
      chk_rng(n, to_tab[s] - 1, to_tab[s] + 2);
    end
    $display("test expiry done");
  endtask : t_expiry

  task automatic t_kick;
    int  n;
    logic seen;
    seen               = 1'b0;
    timeout_period_sel = 2'h0;
    gap                = 16'h000f;
    kick_on            = 1'b1;
    wait_act(1'b0, 100, n);
    repeat (200) begin
      step(1);
      seen |= sys_reset.active;
    end
    chk_bit(1'b0, seen);
    kick_on  = 1'b0;
    idle_lvl = 1'b0;
    wait_act(1'b1, TG + 12, n);
    chk_bit(1'b1, sys_reset.active);
    idle_lvl = 1'b1;
    $display("test kick done");
  endtask : t_kick

  task automatic t_button;
    int  n;
    logic seen;
    seen               = 1'b0;
    timeout_period_sel = 2'h2;
    gap                = 16'h001e;
    kick_on            = 1'b1;
    wait_act(1'b0, 100, n);
    step(10);
    manual_button_reset_n = 1'b0;
    step(2);
    manual_button_reset_n = 1'b1;
    repeat (40) begin
      step(1);
      seen |= sys_reset.active;
    end
    chk_bit(1'b0, seen);
    manual_button_reset_n = 1'b0;
    step(40);
    chk_bit(1'b1, sys_reset.active);
    manual_button_reset_n = 1'b1;
    wait_act(1'b0, 100, n);
    chk_rng(n, HOLD, HOLD + 14);
    $display("test button done");
  endtask : t_button

  task automatic t_supply;
    int n;
    step(10);
    supply_low      = 1'b1;
    supply_trip_sel = 1'b1;
    wait_act(1'b1, 8, n);
    chk_bit(1'b1, sys_reset.active);
    step(8);
    chk_bit(1'b1, trip_level_sel_q);
    manual_button_reset_n = 1'b0;
    step(20);
    manual_button_reset_n = 1'b1;
    step(40);
    chk_bit(1'b1, sys_reset.active);
    supply_low = 1'b0;
    wait_act(1'b0, 100, n);
    chk_rng(n, HOLD, HOLD + 8);
    $display("test supply done");
  endtask : t_supply

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    n_mismatch            = 0;
    compares              = 0;
    rst_n                 = 1'b0;
    supply_low            = 1'b0;
    supply_trip_sel       = 1'b0;
    manual_button_reset_n = 1'b1;
    timeout_period_sel    = 2'h0;
    kick_on               = 1'b0;
    idle_lvl              = 1'b1;
    gap                   = 16'h000f;
    step(11);
    t_power_up();
    t_expiry();
    t_kick();
    t_button();
    t_supply();
    wrap_up();
  end

  // the whole sequence needs little more than a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
endmodule : supervisor_watchdog_reset_tb_top
